// File: rtl/spc_map.svh
/*
 * Constants for the sleep-state power control block: timing counts and reset values.
 * Assumes the includer runs on a 50 MHz clock.
 */
`ifndef SPC_MAP_SVH
`define SPC_MAP_SVH
// ****************************
// Timing
// ****************************
`define SPC_CLK_MHZ 50
`define SPC_DEBOUNCE_MS 16
`define SPC_DEBOUNCE_CYC (`SPC_DEBOUNCE_MS * 1000 * `SPC_CLK_MHZ)
`define SPC_OVERRIDE_S 4
`define SPC_OVERRIDE_CYC (`SPC_OVERRIDE_S * 1000000 * `SPC_CLK_MHZ)
`define SPC_ACTIVE_WELL_POWER_GOOD_US 1
`define SPC_ACTIVE_WELL_POWER_GOOD_CYC (`SPC_ACTIVE_WELL_POWER_GOOD_US * `SPC_CLK_MHZ)
// ****************************
// Reset values
// ****************************
`define SPC_SLEEP_RST 1'b1
`define SPC_BTN_RST 1'b1
`endif

// File: rtl/spc_pkg.sv
/*
 * Types for the sleep-state power control block.
 * Assumes spc_map.svh sits beside it for numeric constants.
 */
package spc_pkg;
   // ****************************
   // States
   // ****************************
   typedef enum logic [4:0] {
      SPC_S0 = 5'h01,
      SPC_S3 = 5'h02,
      SPC_S4 = 5'h04,
      SPC_S5 = 5'h08,
      SPC_DS = 5'h10
   } spc_state_t;

   typedef struct packed {
      logic suspend_ram_sleep_n;
      logic suspend_disk_sleep_n;
      logic soft_off_sleep_n;
      logic active_sleep_n;
      logic wired_phy_sleep_n;
      logic wlan_sleep_n;
      logic s0_idle_sleep_n;
   } spc_sleep_out_t;

   typedef struct packed {
      logic req_s3;
      logic req_s4;
      logic req_s5;
      logic req_wake;
      logic active_off;
      logic wired_phy_off_ok;
      logic wlan_off_ok;
   } spc_ctrl_t;
endpackage : spc_pkg

// File: rtl/spc_sleep_ctrl.sv
/*
 * Sleep-state power control: power button debounce and override, sleep state tracking,
 * and the active-low power plane controls.
 * Assumes a 50 MHz clock and that the resume well reset is already in this clock's domain.
 */
`timescale 1ns/1ps
`include "spc_map.svh"
module spc_sleep_ctrl (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic power_button_n,
   input wire spc_pkg::spc_ctrl_t ctrl,
   input wire logic deep_sleep_enable,
   input wire logic deep_sleep_ready,
   input wire logic wlan_gpio_strap,
   input wire logic wlan_gpio_out,
   input wire logic device_idle,
   input wire logic cpu_deepest_idle,
   output logic system_mgmt_irq_n,
   output logic system_control_irq,
   output logic wake_event,
   output logic override_event,
   output logic active_well_power_good,
   output logic deep_sleep_state,
   output spc_pkg::spc_sleep_out_t sleep_out
);
   import spc_pkg::*;

   localparam int DEB_CYC = `SPC_DEBOUNCE_CYC;
   localparam int OVR_CYC = `SPC_OVERRIDE_CYC;
   localparam int APG_CYC = `SPC_ACTIVE_WELL_POWER_GOOD_CYC;

   // ****************************
   // Button synchroniser and debounce
   // ****************************
   logic btn_s1_q, btn_s2_q, btn_s1_d, btn_s2_d;
   logic btn_q, btn_d;
   logic [19:0] deb_cnt_q, deb_cnt_d;
   logic [27:0] ovr_cnt_q, ovr_cnt_d;
   logic ovr_done_q, ovr_done_d;
   logic press, release_ev, ovr_fire;

   always_comb begin
      btn_s1_d = power_button_n;
      btn_s2_d = btn_s1_q;
      btn_d = btn_q;
      deb_cnt_d = 20'h00000;
      press = 1'b0;
      release_ev = 1'b0;
      // Level must hold a full 16 ms before it is believed
      if (btn_s2_q != btn_q) begin
         if (deb_cnt_q == 20'(DEB_CYC - 1)) begin
            btn_d = btn_s2_q;
            press = ~btn_s2_q;
            release_ev = btn_s2_q;
         end else begin
            deb_cnt_d = deb_cnt_q + 20'h00001;
         end
      end
   end

   always_comb begin
      ovr_cnt_d = ovr_cnt_q;
      ovr_done_d = ovr_done_q;
      ovr_fire = 1'b0;
      if (btn_q) begin
         ovr_cnt_d = 28'h0000000;
         ovr_done_d = 1'b0;
      end else if (!ovr_done_q) begin
         if (ovr_cnt_q == 28'(OVR_CYC - 1)) begin
            ovr_fire = 1'b1;
            ovr_done_d = 1'b1;
         end else begin
            ovr_cnt_d = ovr_cnt_q + 28'h0000001;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         btn_s1_q <= `SPC_BTN_RST;
         btn_s2_q <= `SPC_BTN_RST;
         btn_q <= `SPC_BTN_RST;
         deb_cnt_q <= 20'h00000;
         ovr_cnt_q <= 28'h0000000;
         ovr_done_q <= 1'b0;
      end else begin
         btn_s1_q <= btn_s1_d;
         btn_s2_q <= btn_s2_d;
         btn_q <= btn_d;
         deb_cnt_q <= deb_cnt_d;
         ovr_cnt_q <= ovr_cnt_d;
         ovr_done_q <= ovr_done_d;
      end
   end

   // ****************************
   // Sleep state
   // ****************************
   spc_state_t st_q, st_d;
   logic smi_d, sci_d, wake_d, ovr_ev_d, ds_d;

   always_comb begin
      st_d = st_q;
      smi_d = 1'b1;
      sci_d = 1'b0;
      wake_d = 1'b0;
      ovr_ev_d = 1'b0;
      // Override beats every other request, the press was long
      if (ovr_fire) begin
         st_d = SPC_S5;
         ovr_ev_d = 1'b1;
      end else begin
         case (st_q)
            SPC_S0: begin
               if (press) begin
                  smi_d = 1'b0;
                  sci_d = 1'b1;
               end
               if (ctrl.req_s5) begin
                  st_d = SPC_S5;
               end else if (ctrl.req_s4) begin
                  st_d = SPC_S4;
               end else if (ctrl.req_s3) begin
                  st_d = SPC_S3;
               end
            end
            SPC_S3, SPC_S4, SPC_S5, SPC_DS: begin
               // Wake fires on the debounced press, so a long press can wake and then still hit the override
               if (press) begin
                  wake_d = 1'b1;
               end
               if (ctrl.req_wake) begin
                  st_d = SPC_S0;
               end
            end
            default: st_d = SPC_S0;
         endcase
      end
      // Deep sleep only after an override entry into S5
      if (st_q == SPC_S5 && ovr_done_q && deep_sleep_enable && deep_sleep_ready && !ctrl.req_wake) begin
         st_d = SPC_DS;
      end
      ds_d = (st_d == SPC_DS);
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         st_q <= SPC_S0;
         system_mgmt_irq_n <= 1'b1;
         system_control_irq <= 1'b0;
         wake_event <= 1'b0;
         override_event <= 1'b0;
         deep_sleep_state <= 1'b0;
      end else begin
         st_q <= st_d;
         system_mgmt_irq_n <= smi_d;
         system_control_irq <= sci_d;
         wake_event <= wake_d;
         override_event <= ovr_ev_d;
         deep_sleep_state <= ds_d;
      end
   end

   // ****************************
   // Power plane controls
   // ****************************
   spc_sleep_out_t so_d;
   logic [5:0] apg_cnt_q, apg_cnt_d;
   logic apg_d, in_s0;

   always_comb begin
      in_s0 = (st_d == SPC_S0);
      so_d.suspend_ram_sleep_n = in_s0;
      so_d.suspend_disk_sleep_n = !(st_d == SPC_S4 || st_d == SPC_S5 || st_d == SPC_DS);
      so_d.soft_off_sleep_n = !(st_d == SPC_S5 || st_d == SPC_DS);
      so_d.active_sleep_n = in_s0 || !ctrl.active_off;
      // PHY held powered in S0 and while active well stays up
      so_d.wired_phy_sleep_n = in_s0 || so_d.active_sleep_n || !ctrl.wired_phy_off_ok;
      if (wlan_gpio_strap) begin
         so_d.wlan_sleep_n = wlan_gpio_out;
      end else begin
         so_d.wlan_sleep_n = in_s0 || !ctrl.wlan_off_ok;
      end
      so_d.s0_idle_sleep_n = !(in_s0 && device_idle && cpu_deepest_idle);
      // Power good trails the active well control by a fixed delay
      apg_cnt_d = apg_cnt_q;
      apg_d = 1'b0;
      if (!sleep_out.active_sleep_n) begin
         apg_cnt_d = 6'h00;
      end else if (apg_cnt_q == 6'(APG_CYC)) begin
         apg_d = 1'b1;
      end else begin
         apg_cnt_d = apg_cnt_q + 6'h01;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         sleep_out <= '{default: 1'b1};
         apg_cnt_q <= 6'h00;
         active_well_power_good <= 1'b0;
      end else begin
         sleep_out <= so_d;
         apg_cnt_q <= apg_cnt_d;
         active_well_power_good <= apg_d && so_d.active_sleep_n;
      end
   end

   // ****************************
   // Checks
   // ****************************
   property p_s3_follows;
      @(posedge sys_clk) disable iff (!rst_b) (st_q != SPC_S0) |-> !sleep_out.suspend_ram_sleep_n;
   endproperty
   a_s3_follows: assert property (p_s3_follows) else $error("S3 control not asserted while asleep");

   property p_s4_follows;
      @(posedge sys_clk) disable iff (!rst_b) sleep_out.suspend_disk_sleep_n == (st_q == SPC_S0 || st_q == SPC_S3);
   endproperty
   a_s4_follows: assert property (p_s4_follows) else $error("S4 control wrong for state");

   property p_s5_follows;
      @(posedge sys_clk) disable iff (!rst_b) (st_q == SPC_S5) |-> !sleep_out.soft_off_sleep_n;
   endproperty
   a_s5_follows: assert property (p_s5_follows) else $error("S5 control not asserted in S5");

   property p_phy_on;
      @(posedge sys_clk) disable iff (!rst_b)
         (st_q == SPC_S0 || sleep_out.active_sleep_n) |-> sleep_out.wired_phy_sleep_n;
   endproperty
   a_phy_on: assert property (p_phy_on) else $error("PHY sleep asserted while needed");

   property p_wlan_s0;
      @(posedge sys_clk) disable iff (!rst_b) (st_q == SPC_S0 && !wlan_gpio_strap) |-> sleep_out.wlan_sleep_n;
   endproperty
   a_wlan_s0: assert property (p_wlan_s0) else $error("Wireless sleep asserted in S0");

   property p_override;
      @(posedge sys_clk) disable iff (!rst_b) ovr_fire |=> (st_q == SPC_S5) ##1 !sleep_out.soft_off_sleep_n;
   endproperty
   a_override: assert property (p_override) else $error("Override did not reach S5");

   property p_press_irq;
      @(posedge sys_clk) disable iff (!rst_b) (press && st_q == SPC_S0 && !ovr_fire) |=> !system_mgmt_irq_n && system_control_irq;
   endproperty
   a_press_irq: assert property (p_press_irq) else $error("Press in S0 raised no interrupt");

   property p_press_wake;
      @(posedge sys_clk) disable iff (!rst_b) (press && st_q != SPC_S0 && !ovr_fire) |=> wake_event;
   endproperty
   a_press_wake: assert property (p_press_wake) else $error("Press while asleep gave no wake");

   property p_debounce;
      @(posedge sys_clk) disable iff (!rst_b) $changed(btn_q) |-> ($past(deb_cnt_q) == 20'(DEB_CYC - 1));
   endproperty
   a_debounce: assert property (p_debounce) else $error("Button level changed before debounce");

   property p_apg;
      @(posedge sys_clk) disable iff (!rst_b) $fell(sleep_out.active_sleep_n) |=> !active_well_power_good;
   endproperty
   a_apg: assert property (p_apg) else $error("Power good stayed with well off");
endmodule : spc_sleep_ctrl

// File: sim/spc_platform_model.sv
/*
 * Platform side: resume well reset hold and power rails.
 * Assumes the bench raises wells_valid once the supplies are up.
 */
`timescale 1ns/1ps
module spc_platform_model
   import spc_pkg::*;
#(
   parameter int HOLD_CYC = 4
) (
   input wire logic sys_clk,
   input wire logic wells_valid,
   input wire spc_pkg::spc_sleep_out_t sleep_out,
   output logic rst_b,
   output logic dram_rail_on,
   output logic core_rail_on
);
   // ****
   // Reset hold and rails
   // ****
   int cnt_q = 0;
   always @(posedge sys_clk) begin
      cnt_q <= !wells_valid ? 0 : (cnt_q < HOLD_CYC ? cnt_q + 1 : cnt_q);
   end
   // Released only after the full hold count
   assign rst_b = wells_valid && cnt_q >= HOLD_CYC;
   assign dram_rail_on = sleep_out.suspend_disk_sleep_n;
   assign core_rail_on = sleep_out.suspend_ram_sleep_n;
endmodule : spc_platform_model

// File: sim/sleep_state_power_control_tb_top.sv
/*
 * Directed bench for the sleep control block.
 * Assumes the full 16 ms and 4 s counts, so only sub-debounce button glitches fit the run.
 */
`timescale 1ns/1ps
module sleep_state_power_control_tb_top;
   import spc_pkg::*;
   logic sys_clk = 1'b0;
   logic wv = 1'b0;
   logic btn_n = 1'b1;
   logic strap = 1'b0;
   logic gp = 1'b0;
   logic [1:0] idl = 2'b00;
   spc_ctrl_t ctrl = '0;
   spc_sleep_out_t so;
   logic rst_b, irq_n, irq, wake, ovr, pg, deep, dram_on, core_on;
   int failures = 0;
   int samples_checked = 0;
   int n;
   logic [7:0] st_exp [3] = '{8'h03, 8'h01, 8'h00};
   always #10 sys_clk = ~sys_clk;
   spc_platform_model i_plat (.sys_clk(sys_clk), .wells_valid(wv), .sleep_out(so), .rst_b(rst_b),
      .dram_rail_on(dram_on), .core_rail_on(core_on));
   spc_sleep_ctrl i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .power_button_n(btn_n), .ctrl(ctrl),
      .deep_sleep_enable(1'b1), .deep_sleep_ready(1'b1), .wlan_gpio_strap(strap), .wlan_gpio_out(gp),
      .device_idle(idl[1]), .cpu_deepest_idle(idl[0]), .system_mgmt_irq_n(irq_n),
      .system_control_irq(irq), .wake_event(wake), .override_event(ovr),
      .active_well_power_good(pg), .deep_sleep_state(deep), .sleep_out(so));
   // ****
   // Tasks
   // ****
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic cyc(input int k);
      repeat (k) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask : cyc
   task automatic drv(input logic [6:0] v);
      @(posedge sys_clk);
      ctrl <= v;
      cyc(2);
   endtask : drv
   task automatic final_report;
      $display("checks %0d, mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : final_report
   // ****
   // Sequence
   // ****
   initial begin
      @(posedge sys_clk);
      wv <= 1'b1;
      cyc(6);
      chk("sleep_out", so, 8'h7F);
      chk("flags", {irq_n, irq, wake, ovr, pg, deep}, 8'h20);
      $display("test reset done");
      for (int i = 0; i < 3; i++) begin
         drv(7'h40 >> i);
         chk("plane", so[6:4], st_exp[i]);
         if (i == 0) begin
            drv(7'h70);
            chk("refused", so[6:4], 8'h03);
         end
         drv(7'h08);
         chk("wake", so[6:4], 8'h07);
      end
      $display("test planes done");
      drv(7'h07);
      cyc(60);
      chk("s0_lan", so[3:0], 8'h0F);
      chk("pg_on", pg, 8'h01);
      drv(7'h43);
      chk("asw_on", so[3:1], 8'h06);
      drv(7'h47);
      chk("asw_off", so[3:1], 8'h00);
      chk("pg_off", pg, 8'h00);
      drv(7'h45);
      chk("phy_keep", so[3:1], 8'h02);
      @(posedge sys_clk);
      ctrl <= 7'h08;
      n = 0;
      while (so.active_sleep_n !== 1'b1 && n < 10) begin
         cyc(1);
         n++;
      end
      n = 0;
      while (pg !== 1'b1 && n < 200) begin
         cyc(1);
         n++;
      end
      chk("pg_delay", n, 8'd51);
      if (n == 200) final_report();
      $display("test lan done");
      @(posedge sys_clk);
      strap <= 1'b1;
      cyc(3);
      chk("wlan_gpio0", so.wlan_sleep_n, 8'h00);
      @(posedge sys_clk);
      gp <= 1'b1;
      cyc(3);
      chk("wlan_gpio1", so.wlan_sleep_n, 8'h01);
      @(posedge sys_clk);
      gp <= 1'b0;
      strap <= 1'b0;
      cyc(3);
      chk("wlan_native", so.wlan_sleep_n, 8'h01);
      for (int i = 0; i < 4; i++) begin
         @(posedge sys_clk);
         idl <= 2'(i);
         cyc(3);
         chk("s0_idle", so.s0_idle_sleep_n, (i == 3) ? 8'h00 : 8'h01);
      end
      $display("test pins done");
      // Glitch well short of the debounce span must stay silent
      @(posedge sys_clk);
      idl <= 2'b00;
      btn_n <= 1'b0;
      n = 0;
      repeat (1000) begin
         cyc(1);
         if (irq_n !== 1'b1 || irq !== 1'b0) n++;
      end
      @(posedge sys_clk);
      btn_n <= 1'b1;
      chk("glitch", n, 8'h00);
      $display("test button done");
      drv(7'h20);
      @(posedge sys_clk);
      wv <= 1'b0;
      ctrl <= '0;
      cyc(3);
      chk("mid_reset", so, 8'h7F);
      @(posedge sys_clk);
      wv <= 1'b1;
      cyc(8);
      chk("after_reset", so, 8'h7F);
      $display("test reset again done");
      final_report();
   end
endmodule : sleep_state_power_control_tb_top
